/* File: bench/smi_core_model.sv */
// Purpose: Core-side APB master that drives the interpolator
// Assumes: Slave raises pready when done; the bench watchdog ends a hang
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module smi_core_model (
   input  wire logic               i_clk_sys,
   input  wire smi_pkg::smi_word_t i_prdata,
   input  wire logic               i_pready,
   input  wire logic               i_pslverr,
   output logic                    o_psel,
   output logic                    o_penable,
   output logic                    o_pwrite,
   output logic [11:0]             o_paddr,
   output smi_pkg::smi_word_t      o_pwdata
);
   import smi_pkg::*;
   initial begin
      o_psel    = 1'b0;
      o_penable = 1'b0;
      o_pwrite  = 1'b0;
      o_paddr   = 12'h000;
      o_pwdata  = 32'h0;
   end
   // Request held whole until pready is seen, so no half-released access
   task automatic xfer(input logic wr, input logic [11:0] a, input smi_word_t wd,
                       output smi_word_t rd, output logic err);
      @(posedge i_clk_sys);
      o_psel    <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite  <= wr;
      o_paddr   <= a;
      o_pwdata  <= wd;
      @(posedge i_clk_sys);
      o_penable <= 1'b1;
      do @(posedge i_clk_sys); while (i_pready !== 1'b1);
      rd = i_prdata;
      err = i_pslverr;
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
      o_paddr   <= ~a;
      o_pwdata  <= ~wd;
   endtask
endmodule // smi_core_model
`default_nettype wire

/* File: bench/smi_interp_tb.sv */
// Purpose: Self-checking bench for the two-lane interpolator
// Assumes: Reference model below follows the lane arithmetic
// Notes:   Random contents from a fixed seed; mask top kept at or above bottom
`timescale 1ns/10ps
`default_nettype none
module smi_interp_tb;
   import smi_pkg::*;
   logic        i_clk_sys;
   logic        i_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   smi_word_t   pwdata;
   smi_word_t   prdata;
   logic        pready;
   logic        pslverr;
   int          fail_count;
   int          n_checks;
   bit [31:0]   m_r[5];
   bit [31:0]   m_ctl[2];
   bit [31:0]   r_sm[2];
   bit [31:0]   r_se[2];
   bit [31:0]   r_res[2];
   bit [31:0]   r_full;
   bit          r_ovf[2];

   smi_interp u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
   smi_core_model u_core (.i_clk_sys(i_clk_sys), .i_prdata(prdata), .i_pready(pready),
      .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
      .o_paddr(paddr), .o_pwdata(pwdata));

   initial i_clk_sys = 1'b0;
   always #4 i_clk_sys = ~i_clk_sys;

   function automatic void eval();
      bit [31:0] c;
      bit [31:0] x_in;
      bit [31:0] mk;
      int        lo;
      int        hi;
      int        f;
      longint    b0;
      longint    b1;
      for (int l = 0; l < 2; l++) begin
         c = m_ctl[l];
         lo = c[9:5];
         hi = c[14:10];
         x_in = c[16] ? m_r[1 - l] : m_r[l];
         mk = 32'(((64'h1 << (hi + 1)) - 1) & ~((64'h1 << lo) - 1));
         r_sm[l] = (x_in >> c[4:0]) & mk;
         r_se[l] = r_sm[l];
         if (c[15] && r_sm[l][hi]) begin
            r_se[l] = r_sm[l] | 32'(~((64'h1 << (hi + 1)) - 1));
         end
         r_ovf[l] = ((m_r[l] >> c[4:0]) >> (hi + 1)) != 0;
         r_res[l] = m_r[2 + l] + (c[18] ? x_in : r_se[l]);
      end
      r_full = m_r[4] + r_se[0] + r_se[1];
      if (m_ctl[0][21]) begin
         f = r_sm[1][7:0];
         b0 = m_ctl[1][15] ? longint'($signed(m_r[2])) : longint'(m_r[2]);
         b1 = m_ctl[1][15] ? longint'($signed(m_r[3])) : longint'(m_r[3]);
         r_res[1] = 32'(b0 + (((b1 - b0) * f) >>> 8));
         r_res[0] = 32'(f);
         r_full = m_r[4] + r_se[0];
      end
   endfunction

   function automatic bit [31:0] exp_rd(input logic [11:0] a, output bit e);
      bit [31:0] top0;
      bit [31:0] top1;
      eval();
      top0 = {2'b00, m_ctl[0][20:19], 28'h0};
      top1 = {2'b00, m_ctl[1][20:19], 28'h0};
      e = 1'b0;
      if (a >= 12'h080 && a <= 12'h090) return m_r[(a - 12'h080) >> 2];
      case (a)
         12'h094, 12'h0a0: return r_res[0] | top0;
         12'h098, 12'h0a4: return r_res[1] | top1;
         12'h09c, 12'h0a8: return r_full;
         12'h0ac: return m_ctl[0] | {6'h0, r_ovf[0] | r_ovf[1], r_ovf[1], r_ovf[0], 23'h0};
         12'h0b0: return m_ctl[1];
         default: e = 1'b1;
      endcase
      return 32'h0;
   endfunction

   task automatic chk_val(input smi_word_t got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_err(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t err got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [11:0] a);
      smi_word_t got;
      logic      e;
      bit        ee;
      bit [31:0] x;
      x = exp_rd(a, ee);
      u_core.xfer(1'b0, a, $urandom, got, e);
      chk_val(got, x);
      chk_err(e, ee);
      // Read data is the pre-advance value, so the model updates only now
      if (a inside {12'h094, 12'h098, 12'h09c}) begin
         m_r[0] = m_ctl[0][17] ? r_res[1] : r_res[0];
         m_r[1] = m_ctl[1][17] ? r_res[0] : r_res[1];
      end
   endtask

   task automatic wr(input logic [11:0] a, input bit [31:0] d);
      smi_word_t got;
      logic      e;
      bit        ee;
      ee = !((a >= 12'h080 && a <= 12'h090) || a == 12'h0ac || a == 12'h0b0);
      u_core.xfer(1'b1, a, d, got, e);
      chk_err(e, ee);
      if (a >= 12'h080 && a <= 12'h090) m_r[(a - 12'h080) >> 2] = d;
      if (a == 12'h0ac) m_ctl[0] = d & 32'h003f_ffff;
      if (a == 12'h0b0) m_ctl[1] = d & 32'h001f_ffff;
   endtask

   task automatic do_reset(input int n);
      i_rst <= 1'b1;
      repeat (n) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      m_r = '{default: 0};
      m_ctl = '{default: 0};
   endtask

   task automatic read_all();
      for (int a = 'h080; a <= 'h0b8; a += 4) begin
         rd(12'(a));
      end
   endtask

   task automatic rnd_ctl(output bit [31:0] c);
      c = $urandom;
      c[14:10] = 5'(c[9:5] + $urandom_range(31 - c[9:5]));
   endtask

   task automatic random_round();
      bit [31:0] c0;
      bit [31:0] c1;
      rnd_ctl(c0);
      rnd_ctl(c1);
      wr(12'h080, $urandom);
      wr(12'h084, $urandom);
      wr(12'h088, $urandom);
      wr(12'h08c, $urandom);
      wr(12'h090, $urandom);
      wr(12'h0ac, c0);
      wr(12'h0b0, c1);
      rd(12'h0a0);
      rd(12'h0a4);
      rd(12'h0a8);
      rd(12'h0ac);
      rd(12'h0b0);
      rd(12'h094);
      rd(12'h0a0);
      rd(12'h098);
      rd(12'h09c);
      rd(12'h080);
      rd(12'h084);
      rd(12'h0ac);
   endtask

   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      fail_count = 0;
      n_checks = 0;
      void'($urandom(39));
      do_reset(12);
      read_all();
      $display("test reset_values done");
      for (int i = 0; i < 150; i++) begin
         random_round();
      end
      $display("test random_rounds done");
      wr(12'h0a0, $urandom);
      wr(12'h094, $urandom);
      rd(12'h0fc);
      rd(12'h0a8);
      $display("test refusals done");
      do_reset(2);
      read_all();
      $display("test second_reset done");
      end_sim();
   end

   // Expected run is about 8.7k cycles; limit at 50k cycles
   initial begin
      #400000;
      fail_count++;
      end_sim();
   end
endmodule // smi_interp_tb
`default_nettype wire

/* File: logic/smi_interp.sv */
// Purpose: Two-lane shift-mask interpolator behind an APB slave
// Assumes: APB3 master, zero wait states, one clock
// Notes:   Read data is captured in the setup cycle
// Overview of operation
// (RULE1) Accumulator one is a read-write word feeding lane one, updated on advance.
// (RULE2) Three addend words are read-write and read back as stored.
// (RULE3) Lane zero advance read returns lane zero result and loads both accumulators.
// (RULE4) Lane one advance read returns lane one result and loads both accumulators.
// (RULE5) Combined advance read returns combined result and loads both accumulators.
// (RULE6) View reads return results and change no state.
// (RULE7) Control bit 25 reads the OR of both overflow flags.
// (RULE8) Bits 24 and 23 flag accumulator bits above mask top, one and zero.
// (RULE9) Interpolate mode: lane one blends the addends by lane one's low byte.
// (RULE10) Interpolate mode: lane zero gives only lane one's low byte.
// (RULE11) Interpolate mode: combined is combined addend plus lane zero value.
// (RULE12) Lane one sign setting picks signed or unsigned blending.
// (RULE13) Bits 20:19 are ORed into bus result bits 29:28 only.
// (RULE14) Bypass bit 18 makes lane zero use the raw input; combined unaffected.
// (RULE15) Result cross-feed loads lane zero accumulator with lane one result.
// (RULE16) Input cross-feed feeds lane zero from accumulator one, before bypass.
// (RULE17) Sign bit 15 sign-extends lane zero value before adding.
// (RULE18) Mask passes bits lsb through msb inclusive, others zero.
// (RULE19) Software keeps mask top at or above mask bottom.
// (RULE20) Bits 4:0 give a logical right shift before masking.
// (RULE21) Normally lane result is addend plus value; combined adds both values.
// (RULE22) Control resets to zero; every access completes without wait states.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "smi_map.svh"
module smi_interp #(
   parameter int ADDR_W = `SMI_ADDR_W
) (
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst,
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [ADDR_W-1:0]    i_paddr,
   input  wire smi_pkg::smi_word_t   i_pwdata,
   output smi_pkg::smi_word_t        o_prdata,
   output logic                      o_pready,
   output logic                      o_pslverr
);
   import smi_pkg::*;

   smi_state_t st_q;
   smi_state_t st_d;
   smi_reg_t   reg_sel;
   logic       setup_ph;
   logic       access_ph;
   logic       is_pop;
   logic       is_ro;
   smi_word_t  res0;
   smi_word_t  res1;
   smi_word_t  full;
   smi_word_t  interpolate_mode_val;
   smi_word_t  nxt0;
   smi_word_t  nxt1;
   smi_word_t  ovl0;
   smi_word_t  ovl1;
   smi_word_t  ctrl0_rd;
   smi_word_t  ctrl1_rd;
   logic [`SMI_FRAC_W-1:0] frac;

   smi_lane_if l0_if ();
   smi_lane_if l1_if ();

   assign l0_if.acc_in  = st_q.ctrl0.xin ? st_q.acc1 : st_q.acc0; // see (RULE16)
   assign l0_if.acc_own = st_q.acc0;
   assign l0_if.ctrl    = st_q.ctrl0;
   assign l1_if.acc_in  = st_q.ctrl1.xin ? st_q.acc0 : st_q.acc1;
   assign l1_if.acc_own = st_q.acc1; // see (RULE1)
   assign l1_if.ctrl    = st_q.ctrl1;

   smi_lane u_lane_zero (
      .lif (l0_if.lane)
   );
   smi_lane u_lane_one (
      .lif (l1_if.lane)
   );

   assign frac = l1_if.sm[`SMI_FRAC_W-1:0];

   smi_interpolate_mode u_interpolate_mode (
      .i_lane_zero_addend  (st_q.lane_zero_addend),
      .i_lane_one_addend  (st_q.lane_one_addend),
      .i_frac   (frac),
      .i_signed (st_q.ctrl1.sgn),
      .o_value  (interpolate_mode_val)
   );

   // Lane results; the raw path follows the cross-feed mux
   always_comb begin
      if (st_q.ctrl0.interpolate_mode) begin
         res0 = 32'(frac); // see (RULE10)
         res1 = interpolate_mode_val; // see (RULE9)
         full = st_q.combined_addend + l0_if.sme; // see (RULE11)
      end else begin
         res0 = st_q.lane_zero_addend + (st_q.ctrl0.raw ? l0_if.acc_in : l0_if.sme); // see (RULE14) (RULE21)
         res1 = st_q.lane_one_addend + (st_q.ctrl1.raw ? l1_if.acc_in : l1_if.sme); // see (RULE21)
         full = st_q.combined_addend + l0_if.sme + l1_if.sme; // see (RULE21)
      end
   end

   assign nxt0 = st_q.ctrl0.xres ? res1 : res0; // see (RULE15)
   assign nxt1 = st_q.ctrl1.xres ? res0 : res1;

   // Overlay only on the bus copy so pointer bits never feed back
   always_comb begin
      ovl0 = '0;
      ovl1 = '0;
      ovl0[`SMI_OVL_HI:`SMI_OVL_LO] = st_q.ctrl0.force_top; // see (RULE13)
      ovl1[`SMI_OVL_HI:`SMI_OVL_LO] = st_q.ctrl1.force_top;
      ctrl0_rd = {{(`SMI_DATA_W-`SMI_CTRL_W){1'b0}}, st_q.ctrl0};
      ctrl0_rd[`SMI_BIT_OVF0] = l0_if.ovf; // see (RULE8)
      ctrl0_rd[`SMI_BIT_OVF1] = l1_if.ovf; // see (RULE8)
      ctrl0_rd[`SMI_BIT_OVF]  = l0_if.ovf | l1_if.ovf; // see (RULE7)
      ctrl1_rd = {{(`SMI_DATA_W-`SMI_CTRL_W){1'b0}}, st_q.ctrl1};
   end

   always_comb begin
      case (i_paddr)
         ADDR_W'(`SMI_OFS_ACC0):  reg_sel = SMI_R_ACC0;
         ADDR_W'(`SMI_OFS_ACC1):  reg_sel = SMI_R_ACC1;
         ADDR_W'(`SMI_OFS_LANE_ZERO_ADDEND): reg_sel = SMI_R_LANE_ZERO_ADDEND;
         ADDR_W'(`SMI_OFS_LANE_ONE_ADDEND): reg_sel = SMI_R_LANE_ONE_ADDEND;
         ADDR_W'(`SMI_OFS_COMBINED_ADDEND): reg_sel = SMI_R_COMBINED_ADDEND;
         ADDR_W'(`SMI_OFS_POP0):  reg_sel = SMI_R_POP0;
         ADDR_W'(`SMI_OFS_POP1):  reg_sel = SMI_R_POP1;
         ADDR_W'(`SMI_OFS_POPF):  reg_sel = SMI_R_POPF;
         ADDR_W'(`SMI_OFS_VIEW0): reg_sel = SMI_R_VIEW0;
         ADDR_W'(`SMI_OFS_VIEW1): reg_sel = SMI_R_VIEW1;
         ADDR_W'(`SMI_OFS_VIEWF): reg_sel = SMI_R_VIEWF;
         ADDR_W'(`SMI_OFS_CTRL0): reg_sel = SMI_R_CTRL0;
         ADDR_W'(`SMI_OFS_CTRL1): reg_sel = SMI_R_CTRL1;
         default:                 reg_sel = SMI_R_NONE;
      endcase
   end

   assign setup_ph  = i_psel & ~i_penable;
   assign access_ph = i_psel & i_penable;
   assign is_pop    = (reg_sel == SMI_R_POP0) | (reg_sel == SMI_R_POP1) |
                      (reg_sel == SMI_R_POPF);
   assign is_ro     = is_pop | (reg_sel == SMI_R_VIEW0) | (reg_sel == SMI_R_VIEW1) |
                      (reg_sel == SMI_R_VIEWF);

   always_comb begin
      st_d = st_q;
      // Capturing in setup lets the access edge carry the update
      if (setup_ph) begin
         st_d.slverr = (reg_sel == SMI_R_NONE) | (i_pwrite & is_ro);
         st_d.rdata  = '0;
         if (!i_pwrite) begin
            unique case (reg_sel)
               SMI_R_ACC0:  st_d.rdata = st_q.acc0;
               SMI_R_ACC1:  st_d.rdata = st_q.acc1; // see (RULE1)
               SMI_R_LANE_ZERO_ADDEND: st_d.rdata = st_q.lane_zero_addend; // see (RULE2)
               SMI_R_LANE_ONE_ADDEND: st_d.rdata = st_q.lane_one_addend; // see (RULE2)
               SMI_R_COMBINED_ADDEND: st_d.rdata = st_q.combined_addend; // see (RULE2)
               SMI_R_POP0,
               SMI_R_VIEW0: st_d.rdata = res0 | ovl0; // see (RULE3) (RULE6) (RULE13)
               SMI_R_POP1,
               SMI_R_VIEW1: st_d.rdata = res1 | ovl1; // see (RULE4) (RULE6) (RULE13)
               SMI_R_POPF,
               SMI_R_VIEWF: st_d.rdata = full; // see (RULE5) (RULE6)
               SMI_R_CTRL0: st_d.rdata = ctrl0_rd;
               SMI_R_CTRL1: st_d.rdata = ctrl1_rd;
               SMI_R_NONE:  st_d.rdata = '0;
            endcase
         end
      end
      if (access_ph && i_pwrite) begin
         case (reg_sel)
            SMI_R_ACC0:  st_d.acc0  = i_pwdata;
            SMI_R_ACC1:  st_d.acc1  = i_pwdata; // see (RULE1)
            SMI_R_LANE_ZERO_ADDEND: st_d.lane_zero_addend = i_pwdata; // see (RULE2)
            SMI_R_LANE_ONE_ADDEND: st_d.lane_one_addend = i_pwdata;
            SMI_R_COMBINED_ADDEND: st_d.combined_addend = i_pwdata;
            SMI_R_CTRL0: st_d.ctrl0 = smi_ctrl_t'(i_pwdata[`SMI_CTRL_W-1:0]);
            SMI_R_CTRL1: begin
               st_d.ctrl1       = smi_ctrl_t'(i_pwdata[`SMI_CTRL_W-1:0]);
               st_d.ctrl1.interpolate_mode = 1'b0;
            end
            default: ;
         endcase
      end
      // View addresses fall through here untouched
      if (access_ph && !i_pwrite && is_pop) begin
         st_d.acc0 = nxt0; // see (RULE3) (RULE4) (RULE5)
         st_d.acc1 = nxt1; // see (RULE1)
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_q <= '0; // see (RULE22)
      end else begin
         st_q <= st_d;
      end
   end

   assign o_prdata  = st_q.rdata;
   assign o_pready  = 1'b1; // see (RULE22)
   assign o_pslverr = access_ph & st_q.slverr;

   // Checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   logic rd_setup;
   logic pop_acc;
   smi_word_t win0;
   assign rd_setup = setup_ph & ~i_pwrite;
   assign pop_acc  = access_ph & ~i_pwrite & is_pop;
   assign win0 = (~'0 >> (5'd31 - st_q.ctrl0.msb)) & (~'0 << st_q.ctrl0.lsb);

   a_acc1_write: assert property ( // see (RULE1)
      access_ph && i_pwrite && reg_sel == SMI_R_ACC1 |=> st_q.acc1 == $past(i_pwdata))
      else $error("accumulator one write lost");

   a_acc_reset: assert property ( // see (RULE1)
      $past(i_rst) |-> st_q.acc0 == '0 && st_q.acc1 == '0)
      else $error("accumulators not reset");

   a_base_read: assert property ( // see (RULE2)
      rd_setup && reg_sel == SMI_R_LANE_ONE_ADDEND |=> o_prdata == $past(st_q.lane_one_addend))
      else $error("addend read mismatch");

   a_lane_zero_addend_write: assert property ( // see (RULE2)
      access_ph && i_pwrite && reg_sel == SMI_R_LANE_ZERO_ADDEND |=> st_q.lane_zero_addend == $past(i_pwdata))
      else $error("addend zero write lost");

   a_pop_lane_zero: assert property ( // see (RULE3)
      pop_acc && reg_sel == SMI_R_POP0 |=> st_q.acc0 == $past(nxt0) && st_q.acc1 == $past(nxt1))
      else $error("lane zero advance wrong");

   a_pop_lane_one: assert property ( // see (RULE4)
      rd_setup && reg_sel == SMI_R_POP1 |=> (o_prdata == $past(res1 | ovl1)) and
      (access_ph |=> st_q.acc1 == $past(nxt1)))
      else $error("lane one advance wrong");

   a_pop_full: assert property ( // see (RULE5)
      rd_setup && reg_sel == SMI_R_POPF |=> (o_prdata == $past(full)) and
      (access_ph |=> st_q.acc0 == $past(nxt0)))
      else $error("combined advance wrong");

   a_view_still: assert property ( // see (RULE6)
      access_ph && !i_pwrite && !is_pop |=> $stable(st_q.acc0) && $stable(st_q.acc1))
      else $error("view read changed state");

   a_view_lane_one: assert property ( // see (RULE6)
      rd_setup && reg_sel == SMI_R_VIEW1 |=> o_prdata == $past(res1 | ovl1))
      else $error("lane one view wrong");

   a_ro_refuse: assert property ( // see (RULE6)
      access_ph && i_pwrite && is_ro |-> o_pslverr ##1
      ($stable(st_q.acc0) && $stable(st_q.acc1)))
      else $error("result write not refused");

   a_ovf_or: assert property ( // see (RULE7)
      rd_setup && reg_sel == SMI_R_CTRL0 |=>
      o_prdata[`SMI_BIT_OVF] == (o_prdata[`SMI_BIT_OVF0] | o_prdata[`SMI_BIT_OVF1]))
      else $error("any-overflow not OR");

   a_ovf_one: assert property ( // see (RULE8)
      rd_setup && reg_sel == SMI_R_CTRL0 && st_q.ctrl1.shift == 5'h00 |=>
      o_prdata[`SMI_BIT_OVF1] == $past(|(st_q.acc1 >> st_q.ctrl1.msb >> 1)))
      else $error("overflow one wrong");

   a_ovf_zero: assert property ( // see (RULE8)
      rd_setup && reg_sel == SMI_R_CTRL0 && st_q.ctrl0.shift == 5'h00 |=>
      o_prdata[`SMI_BIT_OVF0] == $past(|(st_q.acc0 >> st_q.ctrl0.msb >> 1)))
      else $error("overflow zero wrong");

   a_interpolate_mode_lane_one: assert property ( // see (RULE9)
      st_q.ctrl0.interpolate_mode && !st_q.ctrl1.sgn && st_q.lane_one_addend >= st_q.lane_zero_addend |->
      res1 == st_q.lane_zero_addend + 32'((64'(st_q.lane_one_addend - st_q.lane_zero_addend) * 64'(frac)) >> 8))
      else $error("interpolate_mode value wrong");

   a_interpolate_mode_lane_zero: assert property ( // see (RULE10)
      rd_setup && reg_sel == SMI_R_VIEW0 && st_q.ctrl0.interpolate_mode && st_q.ctrl0.force_top == 2'h0
      |=> o_prdata == {24'h000000, $past(frac)})
      else $error("interpolate_mode lane zero wrong");

   a_interpolate_mode_full: assert property ( // see (RULE11)
      st_q.ctrl0.interpolate_mode |-> full == st_q.combined_addend + l0_if.sme)
      else $error("interpolate_mode combined wrong");

   a_interpolate_mode_sign: assert property ( // see (RULE12)
      st_q.ctrl0.interpolate_mode && st_q.ctrl1.sgn && st_q.lane_zero_addend[31] && !st_q.lane_one_addend[31] |->
      $signed(res1) >= $signed(st_q.lane_zero_addend) && $signed(res1) <= $signed(st_q.lane_one_addend))
      else $error("signed interpolate_mode out of range");

   a_overlay: assert property ( // see (RULE13)
      rd_setup && reg_sel == SMI_R_VIEW0 |=>
      o_prdata[29:28] == ($past(res0[29:28]) | $past(st_q.ctrl0.force_top)))
      else $error("overlay bits wrong");

   a_raw_path: assert property ( // see (RULE14) (RULE16)
      !st_q.ctrl0.interpolate_mode && st_q.ctrl0.raw && st_q.ctrl0.xin |-> res0 == st_q.lane_zero_addend + st_q.acc1)
      else $error("bypass or input_cross_feed wrong");

   a_raw_own: assert property ( // see (RULE14)
      !st_q.ctrl0.interpolate_mode && st_q.ctrl0.raw && !st_q.ctrl0.xin |-> res0 == st_q.lane_zero_addend + st_q.acc0)
      else $error("bypass on own input wrong");

   a_cross_res: assert property ( // see (RULE15)
      pop_acc && st_q.ctrl0.xres |=> st_q.acc0 == $past(res1))
      else $error("result cross-feed wrong");

   a_cross_one: assert property ( // see (RULE15)
      pop_acc && st_q.ctrl1.xres |=> st_q.acc1 == $past(res0))
      else $error("lane one cross-feed wrong");

   a_sign_ext: assert property ( // see (RULE17)
      st_q.ctrl0.sgn && l0_if.sm[st_q.ctrl0.msb] |-> l0_if.sme[31])
      else $error("sign extension missing");

   a_mask_win: assert property ( // see (RULE18)
      st_q.ctrl0.msb >= st_q.ctrl0.lsb |-> (l0_if.sm & ~win0) == '0)
      else $error("mask leaks bits");

   a_shift_amt: assert property ( // see (RULE20)
      st_q.ctrl0.msb >= st_q.ctrl0.lsb |->
      l0_if.sm == ((l0_if.acc_in >> st_q.ctrl0.shift) & win0))
      else $error("shift wrong");

   a_ctrl_write: assert property ( // see (RULE20)
      access_ph && i_pwrite && reg_sel == SMI_R_CTRL0 |=>
      st_q.ctrl0 == $past(i_pwdata[`SMI_CTRL_W-1:0]))
      else $error("control write lost");

   a_plain_sum: assert property ( // see (RULE21)
      rd_setup && reg_sel == SMI_R_VIEWF && !st_q.ctrl0.interpolate_mode |=>
      o_prdata == $past(st_q.combined_addend + l0_if.sme + l1_if.sme))
      else $error("combined sum wrong");

   a_reset_ctrl: assert property ( // see (RULE22)
      $past(i_rst) |-> st_q.ctrl0 == '0 && st_q.ctrl1 == '0 && o_pready)
      else $error("control not reset");

   c_pop_cross: cover property (pop_acc && st_q.ctrl0.xres);
   c_interpolate_mode_view: cover property (rd_setup && reg_sel == SMI_R_VIEW1 && st_q.ctrl0.interpolate_mode);
   c_overflow: cover property (rd_setup && reg_sel == SMI_R_CTRL0 && l1_if.ovf);
   c_raw_pop: cover property (pop_acc && st_q.ctrl0.raw);
   c_refused: cover property (access_ph && o_pslverr);
endmodule // smi_interp
`default_nettype wire

/* File: logic/smi_interpolate_mode.sv */
// Purpose: Linear interpolate_mode between two addends by an 8-bit fraction
// Assumes: Fraction counts 256ths
// Notes:   Signed or unsigned operands
`timescale 1ns/10ps
`default_nettype none
`include "smi_map.svh"
module smi_interpolate_mode (
   input  wire smi_pkg::smi_word_t      i_lane_zero_addend,
   input  wire smi_pkg::smi_word_t      i_lane_one_addend,
   input  wire logic [`SMI_FRAC_W-1:0]  i_frac,
   input  wire logic                    i_signed,
   output smi_pkg::smi_word_t           o_value
);
   logic signed [33:0] a;
   logic signed [33:0] b;
   logic signed [33:0] diff;
   logic signed [42:0] prod;
   // Widened by two bits so an unsigned difference cannot wrap
   assign a    = i_signed ? 34'(signed'(i_lane_zero_addend)) : {2'b00, i_lane_zero_addend}; // see (RULE12)
   assign b    = i_signed ? 34'(signed'(i_lane_one_addend)) : {2'b00, i_lane_one_addend};
   assign diff = b - a;
   assign prod = diff * $signed({1'b0, i_frac});
   assign o_value = 32'(a + 34'(prod >>> `SMI_FRAC_W)); // see (RULE9)
endmodule // smi_interpolate_mode
`default_nettype wire

/* File: logic/smi_lane.sv */
// Purpose: Shift, mask, sign-extend and overflow for one lane
// Assumes: msb at or above lsb
// Notes:   Combinational
`timescale 1ns/10ps
`default_nettype none
`include "smi_map.svh"
module smi_lane (
   smi_lane_if.lane lif
);
   import smi_pkg::*;
   localparam smi_word_t ONES = '1;
   localparam logic [4:0] TOP = 5'(`SMI_DATA_W - 1);
   smi_word_t upto_msb;
   smi_word_t from_lsb;
   smi_word_t own_sh;
   // Window is undefined when msb < lsb; software keeps it ordered, see (RULE19)
   assign upto_msb = ONES >> (TOP - lif.ctrl.msb);
   assign from_lsb = ONES << lif.ctrl.lsb;
   assign lif.sm   = (lif.acc_in >> lif.ctrl.shift) & upto_msb & from_lsb; // see (RULE18) (RULE20)
   assign lif.sme  = (lif.ctrl.sgn && lif.sm[lif.ctrl.msb]) ?
                     (lif.sm | ~upto_msb) : lif.sm; // see (RULE17)
   assign own_sh   = lif.acc_own >> lif.ctrl.shift;
   assign lif.ovf  = |(own_sh & ~upto_msb); // see (RULE8)
endmodule // smi_lane
`default_nettype wire

/* File: shared/smi_lane_if.sv */
// Purpose: Carries one lane's inputs and shift-mask outputs
// Assumes: Core drives inputs, lane drives results
// Notes:   No clock; purely combinational lane
`timescale 1ns/10ps
`default_nettype none
interface smi_lane_if;
   import smi_pkg::*;
   smi_word_t acc_in;
   smi_word_t acc_own;
   smi_ctrl_t ctrl;
   smi_word_t sm;
   smi_word_t sme;
   logic      ovf;
   modport lane (input acc_in, acc_own, ctrl, output sm, sme, ovf);
   modport core (output acc_in, acc_own, ctrl, input sm, sme, ovf);
endinterface
`default_nettype wire

/* File: shared/smi_map.svh */
// Purpose: Offsets, field positions and reset values of the interpolator
// Assumes: Byte addresses on a 12-bit APB window
// Notes:   Definitions only
`ifndef SMI_MAP_SVH
`define SMI_MAP_SVH
`define SMI_DATA_W       32
`define SMI_ADDR_W       12
`define SMI_OFS_ACC0     12'h080
`define SMI_OFS_ACC1     12'h084
`define SMI_OFS_LANE_ZERO_ADDEND    12'h088
`define SMI_OFS_LANE_ONE_ADDEND    12'h08c
`define SMI_OFS_COMBINED_ADDEND    12'h090
`define SMI_OFS_POP0     12'h094
`define SMI_OFS_POP1     12'h098
`define SMI_OFS_POPF     12'h09c
`define SMI_OFS_VIEW0    12'h0a0
`define SMI_OFS_VIEW1    12'h0a4
`define SMI_OFS_VIEWF    12'h0a8
`define SMI_OFS_CTRL0    12'h0ac
`define SMI_OFS_CTRL1    12'h0b0
`define SMI_CTRL_W       22
`define SMI_BIT_OVF0     23
`define SMI_BIT_OVF1     24
`define SMI_BIT_OVF      25
`define SMI_OVL_LO       28
`define SMI_OVL_HI       29
`define SMI_FRAC_W       8
`define SMI_RST_WORD     32'h0000_0000
`endif

/* File: shared/smi_pkg.sv */
// Purpose: Types shared by the interpolator modules
// Assumes: smi_map.svh carries every number
// Notes:   Control struct follows bits 21:0 of the control word
package smi_pkg;
`include "smi_map.svh"
   typedef logic [`SMI_DATA_W-1:0] smi_word_t;
   typedef struct packed {
      logic       interpolate_mode;
      logic [1:0] force_top;
      logic       raw;
      logic       xres;
      logic       xin;
      logic       sgn;
      logic [4:0] msb;
      logic [4:0] lsb;
      logic [4:0] shift;
   } smi_ctrl_t;
   typedef struct packed {
      smi_word_t acc0;
      smi_word_t acc1;
      smi_word_t lane_zero_addend;
      smi_word_t lane_one_addend;
      smi_word_t combined_addend;
      smi_ctrl_t ctrl0;
      smi_ctrl_t ctrl1;
      smi_word_t rdata;
      logic      slverr;
   } smi_state_t;
   typedef enum logic [3:0] {
      SMI_R_ACC0  = 4'b0000, SMI_R_ACC1  = 4'b0001, SMI_R_LANE_ZERO_ADDEND = 4'b0010,
      SMI_R_LANE_ONE_ADDEND = 4'b0011, SMI_R_COMBINED_ADDEND = 4'b0100, SMI_R_POP0  = 4'b0101,
      SMI_R_POP1  = 4'b0110, SMI_R_POPF  = 4'b0111, SMI_R_VIEW0 = 4'b1000,
      SMI_R_VIEW1 = 4'b1001, SMI_R_VIEWF = 4'b1010, SMI_R_CTRL0 = 4'b1011,
      SMI_R_CTRL1 = 4'b1100, SMI_R_NONE  = 4'b1101
   } smi_reg_t;
endpackage
